// ==== rtl/sslc_pkg.sv ====
package sslc_pkg;

  // ----------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------
  localparam logic [15:0] SSLC_IDX_BREAK_STATUS   = 16'hFE00;
  localparam logic [15:0] SSLC_IDX_RESET_CAUSE    = 16'hFE01;
  localparam logic [15:0] SSLC_IDX_BREAK_FLAG_CTL = 16'hFE03;
  localparam logic [15:0] SSLC_IDX_IRQ_ONE        = 16'hFE04;
  localparam logic [15:0] SSLC_IDX_IRQ_TWO        = 16'hFE05;
  localparam logic [15:0] SSLC_IDX_IRQ_THREE      = 16'hFE06;
  localparam logic [15:0] SSLC_IDX_LP_CTRL        = 16'hFE08;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int SSLC_BIT_EXITED_WAIT = 1;
  localparam int SSLC_BIT_CLEAR_EN    = 0;
  localparam int SSLC_BIT_RC_POWERON  = 7;
  localparam int SSLC_BIT_RC_PIN      = 6;
  localparam int SSLC_BIT_RC_WDOG     = 5;
  localparam int SSLC_BIT_RC_OPCODE   = 4;
  localparam int SSLC_BIT_RC_FETCH    = 3;
  localparam int SSLC_BIT_RC_BROWN    = 1;
  localparam int SSLC_BIT_LP_SHORT    = 0;
  localparam int SSLC_BIT_LP_WDOGDIS  = 1;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] SSLC_RST_IRQ       = 8'h00;
  localparam logic [7:0] SSLC_RST_CAUSE     = 8'h80;
  localparam logic       SSLC_RST_CLEAR_EN  = 1'b0;
  localparam logic       SSLC_RST_EXIT_WAIT = 1'b0;
  localparam logic [1:0] SSLC_RST_LP_CTRL   = 2'h0;

  // ----------------------------------------
  // timing, in oscillator cycles
  // ----------------------------------------
  localparam int          SSLC_CNT_WIDTH    = 13;
  localparam logic [12:0] SSLC_RECOVER_LONG = 13'h1000;
  localparam logic [12:0] SSLC_RECOVER_SHRT = 13'h0020;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    SSLC_RUN,
    SSLC_WAIT,
    SSLC_STOP,
    SSLC_RECOVER
  } sslc_mode_t;

  typedef struct packed {
    logic poweron;
    logic pin;
    logic wdog;
    logic opcode;
    logic fetch;
    logic brownout;
  } sslc_reset_src_t;

  typedef struct packed {
    logic enter_wait;
    logic enter_stop;
    logic break_req;
    logic irq_any;
  } sslc_cpu_evt_t;

endpackage

// ==== rtl/sslc_edge_sync.sv ====
`timescale 1ns/1ns
module sslc_edge_sync
  import sslc_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  // async in, synced out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o,
  output logic      [W-1:0] rise_o
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] last_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
      last_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign sync_o = sync_reg;
  assign rise_o = sync_reg & ~last_reg;

endmodule // sslc_edge_sync

// ==== rtl/sslc_recover_cnt.sv ====
`timescale 1ns/1ns
module sslc_recover_cnt
  import sslc_pkg::*;
(
  // clock and reset
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_n_i,
  // control
  input  wire logic                      osc_fall_i,
  input  wire logic                      hold_i,
  input  wire logic                      short_i,
  output logic                           done_o,
  output logic [SSLC_CNT_WIDTH-1:0]      count_o
);

  logic [SSLC_CNT_WIDTH-1:0] cnt_reg;
  logic [SSLC_CNT_WIDTH-1:0] limit;

  assign limit = short_i ? SSLC_RECOVER_SHRT : SSLC_RECOVER_LONG;

  // counts on the oscillator falling-edge enable
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
    end else if (hold_i) begin
      cnt_reg <= '0;
    end else if (osc_fall_i) begin
      cnt_reg <= cnt_reg + 13'h0001;
    end
  end

  assign done_o  = !hold_i && (cnt_reg >= limit);
  assign count_o = cnt_reg;

endmodule // sslc_recover_cnt

// ==== rtl/sslc_top.sv ====
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
// Behaviour
// - status one: flags 6..1 in bits 7..2, low bits zero
// - status two: flags 14..7 in bits 7..0
// - status three: flags 16,15 in bits 1,0, rest zero
// - flags follow requests, reset zero, writes ignored
// - reset sources equal, above interrupts, no arbitration
// - break forces the software interrupt vector
// - in break, clearing allowed only with clear enable; reset cause read and exited-wait write still clear without it
// - flag cleared in enabled break stays cleared
// - two-step clears protected in break; later step clears
// - wait or stop clears the interrupt mask
// - wait stops cpu clocks only; enabled interrupt wakes
// - reset or break ends wait; break sets exited-wait
// - watchdog runs in wait unless disabled
// - stop clears counter and gates both clock outputs
// - stop ends on interrupt, reset or break; stack after recovery
// - recovery 4096 oscillator cycles, 32 with short option
// - counter held from stop until recovery starts
// - write zero clears exited-wait; set by break exit
// - reset cause holds six source flags, last cause set
// - power-on sets its flag, clears the others
// - reading reset cause clears it
// - counter is 13 bits, steps on oscillator falling edge
module sslc_top
  import sslc_pkg::*;
(
  // clock and reset
  input  wire logic            clk_sys_i,
  input  wire logic            rst_n_i,
  // apb slave
  input  wire logic            psel_i,
  input  wire logic            penable_i,
  input  wire logic            pwrite_i,
  input  wire logic [17:0]     paddr_i,
  input  wire logic [31:0]     pwdata_i,
  input  wire logic [3:0]      pstrb_i,
  output logic      [31:0]     prdata_o,
  output logic                 pready_o,
  output logic                 pslverr_o,
  // peripheral interrupt requests, flag 1 in bit 0
  input  wire logic [15:0]     irq_req_i,
  input  wire logic [15:0]     irq_en_i,
  // reset sources, pulsed from outside the clock domain
  input  wire sslc_reset_src_t reset_src_i,
  // cpu events from the core, same clock
  input  wire sslc_cpu_evt_t   cpu_evt_i,
  // break module output and oscillator clock (pins)
  input  wire logic            break_in_i,
  input  wire logic            oscillator_clock_i,
  // mask options
  input  wire logic            short_recovery_option_i,
  input  wire logic            watchdog_disable_option_i,
  // status-flag clear permission to other modules
  input  wire logic            flag_clear_req_i,
  output logic                 flag_clear_ok_o,
  // cpu control
  output logic                 cpu_reset_o,
  output logic                 cpu_clk_en_o,
  output logic                 periph_clk_en_o,
  output logic                 generator_bus_clock_out_en_o,
  output logic                 oscillator_clock_en_o,
  output logic                 force_swi_vector_o,
  output logic                 clear_imask_o,
  output logic                 stack_start_o,
  output logic                 watchdog_run_o,
  output logic [1:0]           mode_o
);

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  logic [15:0] irq_sync;
  logic [5:0]  rst_rise;
  logic [5:0]  rst_lvl;
  logic        brk_sync;
  logic        brk_rise;
  logic        osc_sync;
  logic        osc_fall_unused;
  logic        osc_last_reg;
  logic        osc_fall;

  sslc_edge_sync #(.W(16)) u_irq_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   (irq_req_i),
    .sync_o    (irq_sync),
    .rise_o    ()
  );

  sslc_edge_sync #(.W(6)) u_rst_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   (reset_src_i),
    .sync_o    (rst_lvl),
    .rise_o    (rst_rise)
  );

  sslc_edge_sync #(.W(2)) u_pin_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({break_in_i, oscillator_clock_i}),
    .sync_o    ({brk_sync, osc_sync}),
    .rise_o    ({brk_rise, osc_fall_unused})
  );

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_last_reg <= 1'b0;
    end else begin
      osc_last_reg <= osc_sync;
    end
  end
  assign osc_fall = osc_last_reg & ~osc_sync;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  function automatic logic hit(input logic [17:0] a, input logic [15:0] idx);
    hit = (a[1:0] == 2'h0) && (a[17:2] == idx);
  endfunction

  logic apb_acc;
  logic apb_wr;
  logic apb_rd;
  logic mapped;

  assign apb_acc = psel_i && penable_i;
  assign apb_wr  = apb_acc && pwrite_i && pstrb_i[0];
  assign apb_rd  = apb_acc && !pwrite_i;
  assign mapped  = hit(paddr_i, SSLC_IDX_BREAK_STATUS) || hit(paddr_i, SSLC_IDX_RESET_CAUSE)
                || hit(paddr_i, SSLC_IDX_BREAK_FLAG_CTL) || hit(paddr_i, SSLC_IDX_IRQ_ONE)
                || hit(paddr_i, SSLC_IDX_IRQ_TWO) || hit(paddr_i, SSLC_IDX_IRQ_THREE)
                || hit(paddr_i, SSLC_IDX_LP_CTRL);

  assign pready_o  = 1'b1;
  assign pslverr_o = apb_acc && !mapped;

  // ----------------------------------------
  // interrupt status flags
  // ----------------------------------------
  logic [15:0] irq_flag_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_flag_reg <= {SSLC_RST_IRQ, SSLC_RST_IRQ};
    end else begin
      irq_flag_reg <= irq_sync;
    end
  end

  // ----------------------------------------
  // reset cause
  // ----------------------------------------
  logic [7:0] cause_reg;
  logic       any_reset;

  assign any_reset = |rst_rise;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cause_reg <= SSLC_RST_CAUSE;
    end else if (rst_rise[5]) begin
      cause_reg <= SSLC_RST_CAUSE;
    end else begin
      // new causes win over a same-cycle read clear
      if (apb_rd && hit(paddr_i, SSLC_IDX_RESET_CAUSE)) begin
        cause_reg <= 8'h00;
      end
      if (rst_rise[4]) cause_reg[SSLC_BIT_RC_PIN] <= 1'b1;
      if (rst_rise[3]) cause_reg[SSLC_BIT_RC_WDOG] <= 1'b1;
      if (rst_rise[2]) cause_reg[SSLC_BIT_RC_OPCODE] <= 1'b1;
      if (rst_rise[1]) cause_reg[SSLC_BIT_RC_FETCH] <= 1'b1;
      if (rst_rise[0]) cause_reg[SSLC_BIT_RC_BROWN] <= 1'b1;
    end
  end

  // ----------------------------------------
  // break state and flag protection
  // ----------------------------------------
  logic clear_en_reg;
  logic in_break_reg;
  logic pend_step_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clear_en_reg <= SSLC_RST_CLEAR_EN;
    end else if (apb_wr && hit(paddr_i, SSLC_IDX_BREAK_FLAG_CTL)) begin
      clear_en_reg <= pwdata_i[SSLC_BIT_CLEAR_EN];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_break_reg <= 1'b0;
    end else if (any_reset) begin
      in_break_reg <= 1'b0;
    end else begin
      in_break_reg <= brk_sync;
    end
  end

  // vector forcing on the break edge, reset first
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      force_swi_vector_o <= 1'b0;
    end else begin
      force_swi_vector_o <= brk_rise && !any_reset;
    end
  end

  // a request held back in break sets pend_step_reg until break ends; nothing acts on it
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_step_reg <= 1'b0;
    end else if (!in_break_reg) begin
      pend_step_reg <= 1'b0;
    end else if (flag_clear_req_i && !clear_en_reg) begin
      pend_step_reg <= 1'b1;
    end
  end

  // clears granted in break are final; blocked ones need a new request after break
  assign flag_clear_ok_o = !in_break_reg || clear_en_reg;

  // ----------------------------------------
  // low-power control
  // ----------------------------------------
  sslc_mode_t mode_reg;
  logic       exit_wait_reg;
  logic [1:0] lp_ctrl_reg;
  logic       hold_cnt;
  logic       rec_done;
  logic       wake_irq;
  logic       short_sel;

  assign wake_irq  = |(irq_sync & irq_en_i);
  assign short_sel = short_recovery_option_i || lp_ctrl_reg[SSLC_BIT_LP_SHORT];
  assign hold_cnt  = (mode_reg == SSLC_STOP);

  sslc_recover_cnt u_cnt (
    .clk_sys_i  (clk_sys_i),
    .rst_n_i    (rst_n_i),
    .osc_fall_i (osc_fall),
    .hold_i     (hold_cnt),
    .short_i    (short_sel),
    .done_o     (rec_done),
    .count_o    ()
  );

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lp_ctrl_reg <= SSLC_RST_LP_CTRL;
    end else if (apb_wr && hit(paddr_i, SSLC_IDX_LP_CTRL)) begin
      lp_ctrl_reg <= pwdata_i[1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg <= SSLC_RUN;
    end else if (any_reset) begin
      mode_reg <= SSLC_RUN;
    end else begin
      unique case (mode_reg)
        SSLC_RUN: begin
          if (cpu_evt_i.enter_stop) begin
            mode_reg <= SSLC_STOP;
          end else if (cpu_evt_i.enter_wait) begin
            mode_reg <= SSLC_WAIT;
          end
        end
        SSLC_WAIT: begin
          if (brk_rise || wake_irq) begin
            mode_reg <= SSLC_RUN;
          end
        end
        SSLC_STOP: begin
          if (brk_rise || wake_irq) begin
            mode_reg <= SSLC_RECOVER;
          end
        end
        SSLC_RECOVER: begin
          if (rec_done) begin
            mode_reg <= SSLC_RUN;
          end
        end
      endcase
    end
  end

  // break exit from wait sets the flag; set beats a same-cycle write of zero
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      exit_wait_reg <= SSLC_RST_EXIT_WAIT;
    end else if (mode_reg == SSLC_WAIT && brk_rise && !any_reset) begin
      exit_wait_reg <= 1'b1;
    end else if (apb_wr && hit(paddr_i, SSLC_IDX_BREAK_STATUS) && !pwdata_i[SSLC_BIT_EXITED_WAIT]) begin
      exit_wait_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clear_imask_o <= 1'b0;
      stack_start_o <= 1'b0;
    end else begin
      clear_imask_o <= mode_reg == SSLC_RUN && (cpu_evt_i.enter_wait || cpu_evt_i.enter_stop);
      stack_start_o <= !any_reset && ((mode_reg == SSLC_WAIT && wake_irq && !brk_rise)
                    || (mode_reg == SSLC_RECOVER && rec_done));
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpu_reset_o <= 1'b1;
    end else begin
      cpu_reset_o <= |rst_lvl;
    end
  end

  assign cpu_clk_en_o                 = (mode_reg == SSLC_RUN);
  assign periph_clk_en_o              = (mode_reg == SSLC_RUN) || (mode_reg == SSLC_WAIT);
  assign generator_bus_clock_out_en_o = (mode_reg != SSLC_STOP) && (mode_reg != SSLC_RECOVER);
  assign oscillator_clock_en_o        = (mode_reg != SSLC_STOP);
  assign watchdog_run_o = !watchdog_disable_option_i && !lp_ctrl_reg[SSLC_BIT_LP_WDOGDIS]
                        && (mode_reg != SSLC_STOP);
  assign mode_o = mode_reg;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    if (hit(paddr_i, SSLC_IDX_BREAK_STATUS)) begin
      rd_byte[SSLC_BIT_EXITED_WAIT] = exit_wait_reg;
    end else if (hit(paddr_i, SSLC_IDX_RESET_CAUSE)) begin
      rd_byte = cause_reg;
    end else if (hit(paddr_i, SSLC_IDX_BREAK_FLAG_CTL)) begin
      rd_byte[SSLC_BIT_CLEAR_EN] = clear_en_reg;
    end else if (hit(paddr_i, SSLC_IDX_IRQ_ONE)) begin
      rd_byte = {irq_flag_reg[5:0], 2'b00};
    end else if (hit(paddr_i, SSLC_IDX_IRQ_TWO)) begin
      rd_byte = irq_flag_reg[13:6];
    end else if (hit(paddr_i, SSLC_IDX_IRQ_THREE)) begin
      rd_byte = {6'b000000, irq_flag_reg[15:14]};
    end else if (hit(paddr_i, SSLC_IDX_LP_CTRL)) begin
      rd_byte = {6'b000000, lp_ctrl_reg};
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= {24'h000000, rd_byte};
    end
  end

endmodule // sslc_top

// ==== dv/sslc_top_chk.sv ====
`timescale 1ns/1ns
module sslc_top_chk
  import sslc_pkg::*;
(
  // clock, reset and bus
  input wire logic            clk_sys_i,
  input wire logic            rst_n_i,
  input wire logic            psel_i,
  input wire logic            penable_i,
  input wire logic            pready_o,
  input wire logic            pslverr_o,
  // events and options
  input wire sslc_reset_src_t reset_src_i,
  input wire sslc_cpu_evt_t   cpu_evt_i,
  input wire logic            break_in_i,
  input wire logic            watchdog_disable_option_i,
  // control outputs
  input wire logic            cpu_reset_o,
  input wire logic            cpu_clk_en_o,
  input wire logic            periph_clk_en_o,
  input wire logic            generator_bus_clock_out_en_o,
  input wire logic            oscillator_clock_en_o,
  input wire logic            force_swi_vector_o,
  input wire logic            clear_imask_o,
  input wire logic            stack_start_o,
  input wire logic            watchdog_run_o,
  input wire logic [1:0]      mode_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  bus_ready_a: assert property (psel_i && penable_i |-> pready_o)
    else $error("no ready");
  bus_err_a: assert property (pslverr_o |-> psel_i && penable_i)
    else $error("stray error");
  lp_entry_a: assert property (mode_o == SSLC_RUN && (cpu_evt_i.enter_wait || cpu_evt_i.enter_stop)
    |=> clear_imask_o && mode_o != SSLC_RUN) else $error("no mask clear");
  wait_clocks_a: assert property (mode_o == SSLC_WAIT |-> !cpu_clk_en_o && periph_clk_en_o)
    else $error("wait clocks");
  stop_gating_a: assert property (mode_o == SSLC_STOP |-> !generator_bus_clock_out_en_o
    && !oscillator_clock_en_o && !cpu_clk_en_o && !periph_clk_en_o) else $error("stop clocks");
  wdog_wait_a: assert property (mode_o == SSLC_WAIT && !watchdog_disable_option_i |-> watchdog_run_o)
    else $error("wdog halted");
  stack_cause_a: assert property (stack_start_o |-> mode_o == SSLC_RUN
    && $past(mode_o) inside {SSLC_WAIT, SSLC_RECOVER}) else $error("stray stack");
  break_vector_a: assert property ($rose(break_in_i) |-> ##[1:5] force_swi_vector_o)
    else $error("no vector");
  swi_pulse_a: assert property (force_swi_vector_o |=> !force_swi_vector_o)
    else $error("long vector");
  reset_prio_a: assert property ($rose(|reset_src_i) |-> ##[1:4] (cpu_reset_o && mode_o == SSLC_RUN))
    else $error("slow reset");
  wait_break_a: assert property (mode_o == SSLC_WAIT && $rose(break_in_i) |-> ##[1:5] mode_o == SSLC_RUN)
    else $error("wait kept");
  recover_hold_a: assert property ($past(mode_o) == SSLC_STOP && mode_o == SSLC_RECOVER
    |-> (mode_o == SSLC_RECOVER) [*8]) else $error("short recovery");
endmodule // sslc_top_chk

bind sslc_top sslc_top_chk sslc_top_chk_inst (.*);

// ==== dv/sslc_core_model.sv ====
`timescale 1ns/1ns
module sslc_core_model #(
  parameter int OSC_HALF = 3
) (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // bench commands
  input  wire logic set_flag_i,
  input  wire logic clear_flag_i,
  // block side
  input  wire logic flag_clear_ok_i,
  output logic      flag_clear_req_o,
  output logic      flag_o,
  output logic      oscillator_clock_o
);
  logic [3:0] osc_cnt_reg;

  // ----------------------------------------
  // oscillator, free running; the block samples it ungated and only drives an enable out
  // ----------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_cnt_reg        <= 4'h0;
      oscillator_clock_o <= 1'b0;
    end else if (osc_cnt_reg == 4'(OSC_HALF - 1)) begin
      osc_cnt_reg        <= 4'h0;
      oscillator_clock_o <= ~oscillator_clock_o;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 4'h1;
    end
  end

  // ----------------------------------------
  // peripheral status flag, cleared only with permission
  // ----------------------------------------
  assign flag_clear_req_o = clear_flag_i;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_o <= 1'b0;
    end else if (set_flag_i) begin
      flag_o <= 1'b1;
    end else if (clear_flag_i && flag_clear_ok_i) begin
      flag_o <= 1'b0;
    end
  end
endmodule // sslc_core_model

// ==== dv/system_status_lowpower_ctrl_test.sv ====
`timescale 1ns/1ns
module system_status_lowpower_ctrl_test
  import sslc_pkg::*;
;
  logic            clk_sys_i   = 1'b0;
  logic            rst_n_i     = 1'b0;
  logic            psel_i      = 1'b0;
  logic            penable_i   = 1'b0;
  logic            pwrite_i    = 1'b0;
  logic [17:0]     paddr_i     = 18'h00000;
  logic [31:0]     pwdata_i    = 32'h00000000;
  logic [15:0]     irq_req_i   = 16'h0000;
  logic [15:0]     irq_en_i    = 16'h0000;
  sslc_reset_src_t reset_src_i = '0;
  sslc_cpu_evt_t   cpu_evt_i   = '0;
  logic            break_in_i  = 1'b0;
  logic            short_opt   = 1'b0;
  logic            set_flag    = 1'b0;
  logic            clr_flag    = 1'b0;
  logic [31:0]     prdata_o;
  logic            pready_o, pslverr_o;
  logic            osc_clk, osc_en, stack_start_o;
  logic [1:0]      mode_o;
  logic            clr_req, clr_ok, flag;
  int              err_total   = 0;
  int              checked     = 0;
  localparam logic [15:0] REQ = 16'hA5C3;

  sslc_top sslc_top_inst (
    .*, .pstrb_i(4'hF), .oscillator_clock_i(osc_clk), .short_recovery_option_i(short_opt),
    .watchdog_disable_option_i(1'b0), .flag_clear_req_i(clr_req), .flag_clear_ok_o(clr_ok), .cpu_reset_o(),
    .cpu_clk_en_o(), .periph_clk_en_o(), .generator_bus_clock_out_en_o(), .oscillator_clock_en_o(osc_en),
    .force_swi_vector_o(), .clear_imask_o(), .watchdog_run_o());

  sslc_core_model sslc_core_model_inst (
    .*, .set_flag_i(set_flag), .clear_flag_i(clr_flag),
    .flag_clear_ok_i(clr_ok), .flag_clear_req_o(clr_req), .flag_o(flag), .oscillator_clock_o(osc_clk));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  // request held until ready
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd, output logic err);
    int n;
    @(posedge clk_sys_i);
    psel_i    <= 1'b1;
    pwrite_i  <= wr;
    paddr_i   <= {idx, 2'b00};
    pwdata_i  <= {24'h000000, wd};
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk_sys_i);
      if (pready_o === 1'b1) break;
    end
    if (n == 16) cmp8(8'h00, 8'h01, "no ready");
    rd = prdata_o[7:0];
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rd_cmp(input logic [15:0] idx, input logic [7:0] exp, input string msg);
    logic [7:0] r;
    logic       e;
    apb(1'b0, idx, 8'h00, r, e);
    cmp8(r, exp, msg);
  endtask

  task automatic evt(input sslc_cpu_evt_t e);
    @(posedge clk_sys_i);
    cpu_evt_i <= e;
    @(posedge clk_sys_i);
    cpu_evt_i <= '0;
    tick(1);
  endtask

  task automatic pulse_flag(input logic clear);
    @(posedge clk_sys_i);
    if (clear) clr_flag <= 1'b1;
    else set_flag <= 1'b1;
    tick(2);
    clr_flag <= 1'b0;
    set_flag <= 1'b0;
    tick(2);
  endtask

  // counts osc falls in recovery
  task automatic wait_stack(output int falls, output logic seen);
    logic prev;
    prev = osc_clk;
    falls = 0;
    seen = 1'b0;
    for (int n = 0; n < 40000 && !seen; n++) begin
      @(posedge clk_sys_i);
      if (mode_o === SSLC_RECOVER && prev === 1'b1 && osc_clk === 1'b0) falls++;
      prev = osc_clk;
      seen = (stack_start_o === 1'b1);
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_values;
    logic [7:0] r;
    logic       e;
    rd_cmp(SSLC_IDX_RESET_CAUSE, 8'h80, "poweron cause");
    rd_cmp(SSLC_IDX_RESET_CAUSE, 8'h00, "cause cleared");
    rd_cmp(SSLC_IDX_IRQ_ONE, 8'h00, "irq one reset");
    rd_cmp(SSLC_IDX_IRQ_TWO, 8'h00, "irq two reset");
    rd_cmp(SSLC_IDX_IRQ_THREE, 8'h00, "irq three reset");
    rd_cmp(SSLC_IDX_BREAK_FLAG_CTL, 8'h00, "enable reset");
    apb(1'b0, 16'hFE02, 8'h00, r, e);
    cmp8(8'(e), 8'h01, "unmapped error");
    cmp8(r, 8'h00, "unmapped data");
    $display("test reset_values done");
  endtask

  task automatic t_irq_map;
    irq_req_i <= REQ;
    tick(6);
    rd_cmp(SSLC_IDX_IRQ_ONE, {REQ[5:0], 2'b00}, "irq one map");
    rd_cmp(SSLC_IDX_IRQ_TWO, REQ[13:6], "irq two map");
    rd_cmp(SSLC_IDX_IRQ_THREE, {6'h00, REQ[15:14]}, "irq three map");
    wr(SSLC_IDX_IRQ_TWO, 8'h00);
    rd_cmp(SSLC_IDX_IRQ_TWO, REQ[13:6], "irq two write");
    irq_req_i <= 16'h0000;
    tick(6);
    rd_cmp(SSLC_IDX_IRQ_ONE, 8'h00, "irq one idle");
    $display("test irq_map done");
  endtask

  task automatic t_reset_cause;
    logic [7:0] exp [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h02};
    for (int i = 0; i < 6; i++) begin
      reset_src_i <= sslc_reset_src_t'(6'h20 >> i);
      tick(4);
      reset_src_i <= '0;
      tick(6);
      rd_cmp(SSLC_IDX_RESET_CAUSE, exp[i], "cause flag");
    end
    $display("test reset_cause done");
  endtask

  task automatic brk(input logic v);
    break_in_i <= v;
    tick(6);
  endtask

  task automatic t_break_protect;
    wr(SSLC_IDX_BREAK_FLAG_CTL, 8'h00);
    pulse_flag(1'b0);
    brk(1'b1);
    pulse_flag(1'b1);
    cmp8(8'(flag), 8'h01, "flag kept");
    cmp8(8'(clr_ok), 8'h00, "clear refused");
    wr(SSLC_IDX_BREAK_FLAG_CTL, 8'h01);
    rd_cmp(SSLC_IDX_BREAK_FLAG_CTL, 8'h01, "enable readback");
    pulse_flag(1'b1);
    cmp8(8'(flag), 8'h00, "flag cleared");
    brk(1'b0);
    cmp8(8'(flag), 8'h00, "flag stays");
    wr(SSLC_IDX_BREAK_FLAG_CTL, 8'h00);
    pulse_flag(1'b0);
    brk(1'b1);
    pulse_flag(1'b1);
    cmp8(8'(flag), 8'h01, "step refused");
    brk(1'b0);
    pulse_flag(1'b1);
    cmp8(8'(flag), 8'h00, "step after");
    $display("test break_protect done");
  endtask

  task automatic t_wait;
    int   f;
    logic s;
    irq_en_i <= 16'h0003;
    evt('{enter_wait: 1'b1, default: 1'b0});
    cmp8(8'(mode_o), 8'(SSLC_WAIT), "wait entered");
    irq_req_i <= 16'h0001;
    wait_stack(f, s);
    cmp8(8'(s), 8'h01, "wake stacking");
    cmp8(8'(mode_o), 8'(SSLC_RUN), "run after wake");
    irq_req_i <= 16'h0000;
    evt('{enter_wait: 1'b1, default: 1'b0});
    brk(1'b1);
    cmp8(8'(mode_o), 8'(SSLC_RUN), "break ends wait");
    rd_cmp(SSLC_IDX_BREAK_STATUS, 8'h02, "exited-wait set");
    break_in_i <= 1'b0;
    wr(SSLC_IDX_BREAK_STATUS, 8'h00);
    rd_cmp(SSLC_IDX_BREAK_STATUS, 8'h00, "exited-wait cleared");
    $display("test wait done");
  endtask

  task automatic t_stop(input logic short_sel, input int exp);
    int   f;
    logic s;
    short_opt <= short_sel;
    evt('{enter_stop: 1'b1, default: 1'b0});
    cmp8(8'(mode_o), 8'(SSLC_STOP), "stop entered");
    cmp8(8'(osc_en), 8'h00, "osc gated");
    tick(20);
    irq_req_i <= 16'h0002;
    wait_stack(f, s);
    cmp8(8'(s), 8'h01, "stop stacking");
    cmp8(8'(f >= exp - 3 && f <= exp + 1), 8'h01, "recovery length");
    irq_req_i <= 16'h0000;
    $display("test stop %0d done", exp);
  endtask

  // ----------------------------------------
  // run
  // ----------------------------------------
  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    #(8 * 60000);
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report();
  end

  initial begin
    tick(6);
    rst_n_i <= 1'b1;
    t_reset_values();
    t_irq_map();
    t_reset_cause();
    t_break_protect();
    t_wait();
    t_stop(1'b1, 32);
    t_stop(1'b0, 4096); // about 196608 ns, under the 480000 ns watchdog
    final_report();
  end
endmodule // system_status_lowpower_ctrl_test
